/* File: crc_unit.sv */
/*
 File: CRC-8 over 16-bit words, one word per clock.
 Assumes: the caller presets before the first word and feeds words in order.
*/
`timescale 1ns/1ps
`include "sensor_cmd_defs.svh"
module crc_unit (
   input wire logic clock_i,
   input wire logic reset_i,
   input wire logic start_i,
   input wire logic word_valid_i,
   input wire logic [15:0] word_i,
   input wire logic mask_low_i,
   output logic [7:0] crc_o
);
   logic [7:0] crc_reg;
   logic [7:0] crc_next;

   // Shifts one word in, most significant bit first.
   function automatic logic [7:0] crc_word(input logic [7:0] crc, input logic [15:0] w);
      logic [8:0] sh;
      sh = {1'b0, crc};
      for (int i = 15; i >= 0; i--) begin
         sh = {sh[7:0], w[i]};
         if (sh[`CRC_TOP_BIT]) begin
            sh = sh ^ `CRC_POLY;
         end
      end
      return sh[7:0];
   endfunction

   // Preset wins over a word in the same cycle; the checksum byte can be masked.
   always_comb begin
      crc_next = crc_reg;
      if (start_i) begin
         crc_next = `CRC_PRESET;
      end else if (word_valid_i) begin
         crc_next = crc_word(crc_reg, mask_low_i ? {word_i[15:8], 8'h00} : word_i);
      end
   end

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         crc_reg <= `CRC_PRESET;
      end else begin
         crc_reg <= crc_next;
      end
   end

   assign crc_o = crc_reg;

   a_crc_preset: assert property (@(posedge clock_i)
      reset_i || start_i |=> crc_o == `CRC_PRESET) else $error("crc not preset");
endmodule

/* File: entry_timer.sv */
/*
 File: command-entry window that opens at power-on reset.
 Assumes: reset_i is the power-on reset; the window never reopens otherwise.
*/
`timescale 1ns/1ps
module entry_timer #(
   parameter int WINDOW_CYCLES = 1000
) (
   input wire logic clock_i,
   input wire logic reset_i,
   output logic window_open_o
);
   localparam int CW = $clog2(WINDOW_CYCLES + 1);
   logic [CW-1:0] count_reg;
   logic [CW-1:0] count_next;

   // Counts down once; zero means the window has closed for good.
   always_comb begin
      count_next = count_reg;
      if (count_reg != '0) begin
         count_next = count_reg - 1'b1;
      end
   end

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         count_reg <= CW'(WINDOW_CYCLES);
      end else begin
         count_reg <= count_next;
      end
   end

   assign window_open_o = count_reg != '0;

   a_window_stays: assert property (@(posedge clock_i) disable iff (reset_i)
      !window_open_o |=> !window_open_o) else $error("window reopened");
endmodule

/* File: link_master.sv */
/*
 Partner model of the programming master, seen through the link decoder.
 Assumes: shares the block's clock; the bench calls its tasks one at a time.
*/
`timescale 1ns/1ps
module link_master (
   input wire logic clock_i,
   input wire logic rd_valid_i,
   input wire logic [15:0] rd_data_i,
   output logic cmd_valid_o,
   output logic [7:0] cmd_byte_o,
   output logic [15:0] cmd_data_o
);
   // Stand-in for the memory programming time; the value is arbitrary.
   localparam int PROG_CYCLES = 8;
   // Idle lines carry a pattern, so that no stale command is mistaken for a live one.
   initial begin
      cmd_valid_o = 1'h0;
      cmd_byte_o = 8'h5a;
      cmd_data_o = 16'ha5a5;
   end
   // One command byte with its word, held from one falling edge to the next.
   task automatic issue(input logic [7:0] cmd, input logic [15:0] data);
      @(negedge clock_i);
      cmd_valid_o = 1'h1;
      cmd_byte_o = cmd;
      cmd_data_o = data;
      @(negedge clock_i);
      cmd_valid_o = 1'h0;
      cmd_byte_o = ~cmd;
      cmd_data_o = ~data;
   endtask
   // A write has no answer; one more cycle lets its effect settle.
   task automatic send_write(input logic [7:0] cmd, input logic [15:0] data);
      issue(cmd, data);
      @(negedge clock_i);
   endtask
   // The answer strobe stands only in the cycle after the taking edge, so sample it at once.
   task automatic send_read(input logic [7:0] cmd, output logic got, output logic [15:0] data);
      issue(cmd, 16'h0000);
      got = rd_valid_i;
      data = rd_data_i;
   endtask
   // A memory write leaves the cells alone for the programming time before the next one.
   task automatic send_nvm_write(input logic [7:0] cmd, input logic [15:0] data);
      issue(cmd, data);
      repeat (PROG_CYCLES) @(negedge clock_i);
   endtask
endmodule

/* File: sensor_cmd_defs.svh */
/*
 File: constants of the command-mode register block and its checksum.
 Assumes: included by bare name; offsets are full command bytes of the link.
*/
// Behaviour
// - Checksum is CRC-8, generator 107h, MSB first.
// - Checksum register presets to all ones.
// - Sixteen words in order, last low byte zeroed.
// - Stored checksum included gives remainder zero.
// - Key register write-only, 94h, key 9BA4h.
// - Status bit 15 shows diagnostic condition, unsuppressed.
// - Bit 14 suppresses diagnostic mode, resets zero.
// - Bit 12 reports undervoltage, read-only.
// - Bit 11 turns pump clock on, resets zero.
// - Bit 8 sticky corrected-error flag per readout.
// - Bit 7 sticky uncorrectable-error flag per readout.
// - Bit 6 sticky field loss, only when enabled.
// - Bit 4 reports start-up checksum failure.
// - Write-enable register 96h/97h, bit 11 permit.
// - Command byte: region, address, read bit.
// - Command mode lasts until power-on reset.
`ifndef SENSOR_CMD_DEFS_SVH
`define SENSOR_CMD_DEFS_SVH
`define CRC_POLY 9'h107
`define CRC_PRESET 8'hff
`define CRC_TOP_BIT 8
`define NVM_WORDS 16
`define NVM_LAST_ADDR 4'hf
`define REGION_NVM 3'h0
`define REGION_REGS 3'h4
`define CMD_STATUS_WR 8'h82
`define CMD_STATUS_RD 8'h83
`define CMD_KEY_WR 8'h94
`define CMD_WEN_WR 8'h96
`define CMD_WEN_RD 8'h97
`define UNLOCK_KEY 16'h9ba4
`define WEN_RESET 16'h0605
`define WEN_FIXED_MASK 16'h0605
`define BIT_DIAG 15
`define BIT_SUPPRESS 14
`define BIT_UNDERVOLT 12
`define BIT_PUMP 11
`define BIT_CORR 8
`define BIT_UNCORR 7
`define BIT_FIELD 6
`define BIT_CRC_BAD 4
`define STATUS_RESERVED 16'h262f
`define BIT_PERMIT 11
`define CLOCK_PERIOD_NS 4
`endif

/* File: sensor_cmd_pkg.sv */
/*
 File: types shared by the command-mode register block.
 Assumes: referenced only by scoped names, never imported.
*/
package sensor_cmd_pkg;
   // Command byte as it arrives from the link decoder.
   typedef struct packed {
      logic [2:0] region;
      logic [3:0] addr;
      logic rd;
   } link_cmd_s;
   // Analog status levels from the sensor front end.
   typedef struct packed {
      logic diag;
      logic undervolt;
      logic field_loss;
   } status_in_s;
   // Start-up checksum walk.
   typedef enum logic [1:0] {st_check, st_run} startup_e;
endpackage

/* File: sensor_command_registers_crc.sv */
/*
 File: command-mode registers and start-up checksum check of the angle sensor.
 Assumes: a same-clock link decoder delivers each command byte with its data
 word as a one-cycle strobe; memory readout logic streams the sixteen words
 after reset and reports error-correction results; status levels are async.
*/
`timescale 1ns/1ps
`include "sensor_cmd_defs.svh"
module sensor_command_registers_crc #(
   parameter int ENTRY_WINDOW_NS = 20000000,
   parameter int ENTRY_WINDOW_CYCLES = ENTRY_WINDOW_NS / `CLOCK_PERIOD_NS
) (
   input wire logic clock_i,
   input wire logic reset_i,
   input wire logic cmd_valid_i,
   input wire logic [7:0] cmd_byte_i,
   input wire logic [15:0] cmd_data_i,
   output logic rd_valid_o,
   output logic [15:0] rd_data_o,
   input wire logic nvm_word_valid_i,
   input wire logic [3:0] nvm_addr_i,
   input wire logic [15:0] nvm_word_i,
   input wire logic nvm_readout_i,
   input wire logic nvm_corrected_i,
   input wire logic nvm_uncorrectable_i,
   input wire logic field_loss_enable_i,
   input wire sensor_cmd_pkg::status_in_s status_i,
   output logic command_mode_o,
   output logic diag_mode_o,
   output logic pump_clock_on_o,
   output logic nvm_write_permit_o,
   output logic check_done_o,
   output logic [7:0] checksum_o
);
   sensor_cmd_pkg::link_cmd_s cmd;
   sensor_cmd_pkg::status_in_s sync1_reg;
   sensor_cmd_pkg::status_in_s sync2_reg;
   sensor_cmd_pkg::startup_e state_reg;
   sensor_cmd_pkg::startup_e state_next;
   logic [3:0] expect_reg;
   logic [3:0] expect_next;
   logic feed;
   logic last_word;
   logic [7:0] check_crc;
   logic [7:0] sum_crc;
   logic window_open;
   logic mode_reg;
   logic mode_next;
   logic suppress_reg;
   logic suppress_next;
   logic pump_reg;
   logic pump_next;
   logic permit_reg;
   logic permit_next;
   logic corr_reg;
   logic corr_next;
   logic uncorr_reg;
   logic uncorr_next;
   logic field_reg;
   logic field_next;
   logic diag_cond;
   logic diag_reg;
   logic diag_next;
   logic rd_valid_reg;
   logic rd_valid_next;
   logic [15:0] rd_data_reg;
   logic [15:0] rd_data_next;
   logic [15:0] status_word;
   logic [15:0] wen_word;
   logic key_ok;

   // Tells whether a command byte addresses the register region.
   function automatic logic is_reg_cmd(input logic [7:0] b);
      sensor_cmd_pkg::link_cmd_s c;
      c = b;
      return c.region == `REGION_REGS;
   endfunction

   // Two flip-flops per status level before any logic reads it.
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
      end else begin
         sync1_reg <= status_i;
         sync2_reg <= sync1_reg;
      end
   end

   assign cmd = cmd_byte_i;

   // Window that admits the unlock key after power-on reset.
   entry_timer #(
      .WINDOW_CYCLES(ENTRY_WINDOW_CYCLES)
   ) u_window (
      .clock_i(clock_i),
      .reset_i(reset_i),
      .window_open_o(window_open)
   );

   // Start-up walk: words taken only in increasing address order.
   assign feed = (state_reg == sensor_cmd_pkg::st_check) && nvm_word_valid_i
      && (nvm_addr_i == expect_reg);
   assign last_word = nvm_addr_i == `NVM_LAST_ADDR;

   // Check remainder runs over the stored checksum as it is.
   crc_unit u_check (
      .clock_i(clock_i),
      .reset_i(reset_i),
      .start_i(1'b0),
      .word_valid_i(feed),
      .word_i(nvm_word_i),
      .mask_low_i(1'b0),
      .crc_o(check_crc)
   );

   // Fresh checksum runs with the checksum byte of the last word zeroed.
   crc_unit u_sum (
      .clock_i(clock_i),
      .reset_i(reset_i),
      .start_i(1'b0),
      .word_valid_i(feed),
      .word_i(nvm_word_i),
      .mask_low_i(last_word),
      .crc_o(sum_crc)
   );

   // Start-up check state: moves from st_check to st_run once the last word is taken.
   always_comb begin
      state_next = state_reg;
      expect_next = expect_reg;
      unique case (state_reg)
         sensor_cmd_pkg::st_check: begin
            if (feed) begin
               expect_next = expect_reg + 4'h1;
               if (last_word) begin
                  state_next = sensor_cmd_pkg::st_run;
               end
            end
         end
         sensor_cmd_pkg::st_run: begin
            expect_next = expect_reg;
         end
         default: begin
            state_next = sensor_cmd_pkg::st_check;
         end
      endcase
   end

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         state_reg <= sensor_cmd_pkg::st_check;
         expect_reg <= 4'h0;
      end else begin
         state_reg <= state_next;
         expect_reg <= expect_next;
      end
   end

   // The remainder settles one cycle after the last word is taken.
   logic judge_reg;
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         judge_reg <= 1'b0;
      end else begin
         judge_reg <= feed && last_word;
      end
   end

   // Failure latched from the settled remainder; nonzero means damaged.
   logic bad_reg;
   logic bad_next;
   always_comb begin
      bad_next = bad_reg;
      if (judge_reg) begin
         bad_next = check_crc != 8'h00;
      end
   end

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         bad_reg <= 1'b0;
      end else begin
         bad_reg <= bad_next;
      end
   end

   // Key accepted inside the window, or any time diagnostic mode is active.
   assign key_ok = cmd_valid_i && cmd_byte_i == `CMD_KEY_WR
      && cmd_data_i == `UNLOCK_KEY && (window_open || diag_reg);

   // Error and field-loss flags only ever rise until power-on reset.
   assign diag_cond = sync2_reg.diag || field_reg;

   // Control bits, mode and sticky flags.
   always_comb begin
      mode_next = mode_reg || key_ok;
      suppress_next = suppress_reg;
      pump_next = pump_reg;
      permit_next = permit_reg;
      if (mode_reg && cmd_valid_i && !cmd.rd && is_reg_cmd(cmd_byte_i)) begin
         if (cmd_byte_i == `CMD_STATUS_WR) begin
            suppress_next = cmd_data_i[`BIT_SUPPRESS];
            pump_next = cmd_data_i[`BIT_PUMP];
         end
         if (cmd_byte_i == `CMD_WEN_WR) begin
            permit_next = cmd_data_i[`BIT_PERMIT];
         end
      end
      corr_next = corr_reg || (nvm_readout_i && nvm_corrected_i);
      uncorr_next = uncorr_reg || (nvm_readout_i && nvm_uncorrectable_i);
      field_next = field_reg || (field_loss_enable_i && sync2_reg.field_loss);
      diag_next = diag_cond && !suppress_reg;
   end

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         mode_reg <= 1'b0;
         suppress_reg <= 1'b0;
         pump_reg <= 1'b0;
         permit_reg <= 1'b0;
         corr_reg <= 1'b0;
         uncorr_reg <= 1'b0;
         field_reg <= 1'b0;
         diag_reg <= 1'b0;
      end else begin
         mode_reg <= mode_next;
         suppress_reg <= suppress_next;
         pump_reg <= pump_next;
         permit_reg <= permit_next;
         corr_reg <= corr_next;
         uncorr_reg <= uncorr_next;
         field_reg <= field_next;
         diag_reg <= diag_next;
      end
   end

   // Read images; reserved status bits are zero, write-enable keeps its pattern.
   always_comb begin
      status_word = 16'h0000;
      status_word[`BIT_DIAG] = diag_cond;
      status_word[`BIT_SUPPRESS] = suppress_reg;
      status_word[`BIT_UNDERVOLT] = sync2_reg.undervolt;
      status_word[`BIT_PUMP] = pump_reg;
      status_word[`BIT_CORR] = corr_reg;
      status_word[`BIT_UNCORR] = uncorr_reg;
      status_word[`BIT_FIELD] = field_reg;
      status_word[`BIT_CRC_BAD] = bad_reg;
      wen_word = `WEN_FIXED_MASK;
      wen_word[`BIT_PERMIT] = permit_reg;
   end

   // Read answer one cycle after the command; unmapped reads answer zero.
   always_comb begin
      rd_valid_next = mode_reg && cmd_valid_i && cmd.rd;
      rd_data_next = rd_data_reg;
      if (rd_valid_next) begin
         rd_data_next = 16'h0000;
         if (cmd_byte_i == `CMD_STATUS_RD) begin
            rd_data_next = status_word;
         end
         if (cmd_byte_i == `CMD_WEN_RD) begin
            rd_data_next = wen_word;
         end
      end
   end

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         rd_valid_reg <= 1'b0;
         rd_data_reg <= 16'h0000;
      end else begin
         rd_valid_reg <= rd_valid_next;
         rd_data_reg <= rd_data_next;
      end
   end

   assign rd_valid_o = rd_valid_reg;
   assign rd_data_o = rd_data_reg;
   assign command_mode_o = mode_reg;
   assign diag_mode_o = diag_reg;
   assign pump_clock_on_o = pump_reg;
   assign nvm_write_permit_o = permit_reg;
   assign check_done_o = state_reg == sensor_cmd_pkg::st_run && !judge_reg;
   assign checksum_o = sum_crc;

   a_key_entry: assert property (@(posedge clock_i) disable iff (reset_i)
      key_ok |=> command_mode_o) else $error("key did not enter mode");
   a_mode_sticky: assert property (@(posedge clock_i) disable iff (reset_i)
      command_mode_o |=> command_mode_o) else $error("command mode left");
   a_key_late: assert property (@(posedge clock_i) disable iff (reset_i)
      !window_open && !diag_reg && !command_mode_o |=> !command_mode_o)
      else $error("mode entered outside window");
   a_suppress_off: assert property (@(posedge clock_i) disable iff (reset_i)
      suppress_reg |=> !diag_mode_o) else $error("diag not suppressed");
   a_diag_bit: assert property (@(posedge clock_i) disable iff (reset_i)
      command_mode_o && cmd_valid_i && cmd_byte_i == `CMD_STATUS_RD
      |=> rd_valid_o && rd_data_o[`BIT_DIAG] == $past(diag_cond))
      else $error("diag bit wrong");
   a_uv_bit: assert property (@(posedge clock_i) disable iff (reset_i)
      command_mode_o && cmd_valid_i && cmd_byte_i == `CMD_STATUS_RD
      |=> rd_data_o[`BIT_UNDERVOLT] == $past(sync2_reg.undervolt))
      else $error("undervoltage bit wrong");
   a_reserved_zero: assert property (@(posedge clock_i) disable iff (reset_i)
      rd_valid_o && $past(cmd_byte_i) == `CMD_STATUS_RD
      |-> (rd_data_o & `STATUS_RESERVED) == 16'h0000) else $error("reserved bit set");
   a_pump_write: assert property (@(posedge clock_i) disable iff (reset_i)
      command_mode_o && cmd_valid_i && cmd_byte_i == `CMD_STATUS_WR
      |=> pump_clock_on_o == $past(cmd_data_i[`BIT_PUMP]))
      else $error("pump clock not written");
   a_corr_sticky: assert property (@(posedge clock_i) disable iff (reset_i)
      nvm_readout_i && nvm_corrected_i |=> corr_reg [*2])
      else $error("corrected flag lost");
   a_uncorr_sticky: assert property (@(posedge clock_i) disable iff (reset_i)
      nvm_readout_i && nvm_uncorrectable_i |=> uncorr_reg [*2])
      else $error("uncorrectable flag lost");
   a_field_gate: assert property (@(posedge clock_i) disable iff (reset_i)
      !field_reg && !field_loss_enable_i |=> !field_reg)
      else $error("field loss without enable");
   a_crc_judge: assert property (@(posedge clock_i) disable iff (reset_i)
      judge_reg |=> bad_reg == ($past(check_crc) != 8'h00))
      else $error("checksum verdict wrong");
   a_permit_write: assert property (@(posedge clock_i) disable iff (reset_i)
      command_mode_o && cmd_valid_i && cmd_byte_i == `CMD_WEN_WR
      |=> nvm_write_permit_o == $past(cmd_data_i[`BIT_PERMIT]))
      else $error("write permit not written");
endmodule

/* File: sensor_command_registers_crc_tb_top.sv */
/*
 Testbench of the command-mode registers and start-up checksum check.
 Assumes: design files and link_master compiled first; one 250 MHz clock.
*/
`timescale 1ns/1ps
module sensor_command_registers_crc_tb_top;
   logic clock, reset, cmd_valid, rd_valid, nvm_valid, readout, corr, uncorr, fl_en;
   logic cmd_mode, diag_mode, pump, permit, done, got;
   logic [7:0] cmd_byte, csum, exp_crc;
   logic [15:0] cmd_data, rd_data, nvm_word, rdata;
   logic [3:0] nvm_addr;
   logic [15:0] words [16];
   sensor_cmd_pkg::status_in_s st;
   int fails, n_compared, cycles;

   sensor_command_registers_crc #(.ENTRY_WINDOW_CYCLES(50)) dut (
      .clock_i(clock), .reset_i(reset), .cmd_valid_i(cmd_valid), .cmd_byte_i(cmd_byte),
      .cmd_data_i(cmd_data), .rd_valid_o(rd_valid), .rd_data_o(rd_data),
      .nvm_word_valid_i(nvm_valid), .nvm_addr_i(nvm_addr), .nvm_word_i(nvm_word),
      .nvm_readout_i(readout), .nvm_corrected_i(corr), .nvm_uncorrectable_i(uncorr),
      .field_loss_enable_i(fl_en), .status_i(st), .command_mode_o(cmd_mode),
      .diag_mode_o(diag_mode), .pump_clock_on_o(pump), .nvm_write_permit_o(permit),
      .check_done_o(done), .checksum_o(csum));

   link_master master (
      .clock_i(clock), .rd_valid_i(rd_valid), .rd_data_i(rd_data),
      .cmd_valid_o(cmd_valid), .cmd_byte_o(cmd_byte), .cmd_data_o(cmd_data));

   // Free-running 4 ns clock.
   initial begin
      clock = 1'h0;
      forever #2 clock = ~clock;
   end

   // Cuts a hang short well beyond the expected run of a few hundred cycles.
   always @(posedge clock) begin
      cycles++;
      if (cycles == 3000) begin
         fails++;
         conclude();
      end
   end

   // Reference checksum: shift each bit in MSB first, fold the generator at bit 8.
   function automatic logic [7:0] crc_word(input logic [7:0] c, input logic [15:0] w);
      logic [8:0] s;
      s = {1'h0, c};
      for (int i = 15; i >= 0; i--) begin
         s = {s[7:0], w[i]};
         if (s[8]) s = s ^ 9'h107;
      end
      return s[7:0];
   endfunction

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         $display("ERROR %s expected %h seen %h", name, exp, seen);
         fails++;
      end
   endtask

   task automatic flag(input string name, input logic seen, input logic exp);
      check(name, {15'h0, seen}, {15'h0, exp});
   endtask

   // A read must be answered with the strobe and the expected word.
   task automatic rd_chk(input string name, input logic [7:0] cmd, input logic [15:0] exp);
      master.send_read(cmd, got, rdata);
      flag({name, " strobe"}, got, 1'h1);
      check(name, rdata, exp);
   endtask

   task automatic do_reset();
      reset = 1'h1;
      repeat (8) @(negedge clock);
      reset = 1'h0;
   endtask

   // Start-up words in order, led by one out-of-order word that must be ignored.
   task automatic stream(input logic [15:0] last);
      @(negedge clock);
      nvm_valid = 1'h1;
      nvm_addr = 4'h3;
      nvm_word = 16'hdead;
      for (int i = 0; i < 16; i++) begin
         @(negedge clock);
         nvm_addr = i[3:0];
         nvm_word = (i == 15) ? last : words[i];
      end
      @(negedge clock);
      nvm_valid = 1'h0;
      nvm_word = ~nvm_word;
      for (int i = 0; i < 40 && done !== 1'h1; i++) @(negedge clock);
   endtask

   // One memory readout event with its correction results.
   task automatic pulse(input logic c, input logic u);
      @(negedge clock);
      readout = 1'h1;
      corr = c;
      uncorr = u;
      @(negedge clock);
      readout = 1'h0;
      corr = 1'h0;
      uncorr = 1'h0;
      @(negedge clock);
   endtask

   // Status levels pass two synchroniser stages, so allow four cycles.
   task automatic set_st(input logic [2:0] v);
      st = v;
      repeat (4) @(negedge clock);
   endtask

   task automatic conclude();
      $display("Compared %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // Main sequence: unlock in the window, then a late unlock after a second reset.
   initial begin
      reset = 1'h1;
      nvm_valid = 1'h0;
      nvm_addr = 4'h0;
      nvm_word = 16'h0000;
      readout = 1'h0;
      corr = 1'h0;
      uncorr = 1'h0;
      fl_en = 1'h0;
      st = 3'h0;
      fails = 0;
      n_compared = 0;
      cycles = 0;
      words = '{16'h1111, 16'h2222, 16'h3333, 16'h4444, 16'h5555, 16'h6666, 16'h7777,
         16'h8888, 16'h9999, 16'haaaa, 16'hbbbb, 16'hcccc, 16'hdddd, 16'heeee, 16'hffff,
         16'h4200};
      exp_crc = 8'hff;
      foreach (words[i]) exp_crc = crc_word(exp_crc, words[i]);
      do_reset();
      check("checksum preset", {8'h0, csum}, 16'h00ff);
      master.send_read(8'h83, got, rdata);
      flag("locked read", got, 1'h0);
      master.send_write(8'h94, 16'h1234);
      flag("wrong key", cmd_mode, 1'h0);
      master.send_write(8'h94, 16'h9ba4);
      flag("key in window", cmd_mode, 1'h1);
      stream(words[15] | {8'h0, exp_crc});
      flag("check done", done, 1'h1);
      check("checksum", {8'h0, csum}, {8'h0, exp_crc});
      rd_chk("status clean", 8'h83, 16'h0000);
      set_st(3'h2);
      master.send_write(8'h96, 16'h0e05);
      flag("permit", permit, 1'h1);
      rd_chk("wen enabled", 8'h97, 16'h0e05);
      master.send_write(8'h82, 16'hffff);
      flag("pump", pump, 1'h1);
      rd_chk("status set", 8'h83, 16'h5800);
      master.send_nvm_write(8'h16, 16'h0000);
      flag("nvm write ignored", permit, 1'h1);
      master.send_nvm_write(8'h1e, words[15] | {8'h0, exp_crc});
      rd_chk("nvm read", 8'h1f, 16'h0000);
      pulse(1'h1, 1'h0);
      pulse(1'h0, 1'h0);
      rd_chk("corrected", 8'h83, 16'h5900);
      pulse(1'h0, 1'h1);
      rd_chk("uncorrectable", 8'h83, 16'h5980);
      set_st(3'h3);
      rd_chk("loss disabled", 8'h83, 16'h5980);
      fl_en = 1'h1;
      set_st(3'h3);
      rd_chk("loss enabled", 8'h83, 16'hd9c0);
      flag("suppressed", diag_mode, 1'h0);
      set_st(3'h2);
      master.send_write(8'h82, 16'h0000);
      rd_chk("loss sticky", 8'h83, 16'h91c0);
      flag("diag mode", diag_mode, 1'h1);
      flag("pump off", pump, 1'h0);
      master.send_write(8'h96, 16'h0605);
      flag("permit off", permit, 1'h0);
      rd_chk("wen default", 8'h97, 16'h0605);
      master.send_write(8'h94, 16'h0000);
      rd_chk("key unreadable", 8'h95, 16'h0000);
      flag("mode kept", cmd_mode, 1'h1);
      fl_en = 1'h0;
      st = 3'h0;
      do_reset();
      flag("mode cleared", cmd_mode, 1'h0);
      stream(words[15] | {8'h0, exp_crc ^ 8'h01});
      repeat (40) @(negedge clock);
      master.send_write(8'h94, 16'h9ba4);
      flag("late key", cmd_mode, 1'h0);
      set_st(3'h4);
      flag("diag raised", diag_mode, 1'h1);
      master.send_write(8'h94, 16'h9ba4);
      flag("diag key", cmd_mode, 1'h1);
      rd_chk("crc bad", 8'h83, 16'h8010);
      check("checksum masked", {8'h0, csum}, {8'h0, exp_crc});
      conclude();
   end
endmodule
